// ---- serial_frame_defs.svh ----
// constants for the asynchronous serial frame block
// assumes inclusion by bare name from the design files
`ifndef SERIAL_FRAME_DEFS_SVH
`define SERIAL_FRAME_DEFS_SVH

// ----------------------------------------------------------------
// bit timing
// ----------------------------------------------------------------
`define SF_OS_W        4
`define SF_OS_LAST     4'hF
`define SF_OS_MID      4'h7
`define SF_OS_ZERO     4'h0

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SF_BIT_W       4
`define SF_BIT_ZERO    4'h0
`define SF_DATA_LAST_8 4'h7
`define SF_DATA_LAST_9 4'h8
`define SF_FRAME_8     4'hA
`define SF_FRAME_9     4'hB

// ----------------------------------------------------------------
// fifo and reset values
// ----------------------------------------------------------------
`define SF_FIFO_DEPTH  16
`define SF_WORD_W      9
`define SF_WORD_ZERO   9'h000
`define SF_LINE_IDLE   1'b1

`endif

// ---- serial_frame_pkg.sv ----
// state types for the asynchronous serial frame block
// assumes nothing of its surroundings
package serial_frame_pkg;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_START,
		TX_DATA,
		TX_STOP,
		TX_BREAK,
		TX_MARK,
		TX_IDLE_CH
	} tx_state_e;

	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} rx_state_e;

endpackage : serial_frame_pkg

// ---- word_stream_if.sv ----
// valid/ready word stream between the block's own modules
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface word_stream_if #(
	parameter int WIDTH = 9
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface : word_stream_if

// ---- frame_fifo.sv ----
// synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`include "serial_frame_defs.svh"

module frame_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic     clock_i,
	input  wire logic     sys_rst_i,
	word_stream_if.sink   fill_s,
	word_stream_if.source drain_s
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    wr_d;
	logic [AW-1:0]    rd_q;
	logic [AW-1:0]    rd_d;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             pop;

	// ----------------------------------------------------------------
	// pointers and fill level
	// ----------------------------------------------------------------
	assign fill_s.ready  = (cnt_q < (AW+1)'(DEPTH));
	assign drain_s.valid = (cnt_q != '0);
	assign drain_s.data  = mem_q[rd_q];
	assign push          = fill_s.valid & fill_s.ready;
	assign pop           = drain_s.valid & drain_s.ready;

	always_comb begin
		wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
		rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = (AW+1)'(cnt_q + 1'b1);
		end else if (pop && !push) begin
			cnt_d = (AW+1)'(cnt_q - 1'b1);
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// storage carries no reset; only written words are ever read
	always_ff @(posedge clock_i) begin
		if (push) begin
			mem_q[wr_q] <= fill_s.data;
		end
	end

endmodule : frame_fifo

// ---- async_serial_frame_format.sv ----
// asynchronous serial frame engine: transmit and receive framing
// assumes rxd_i is asynchronous, control inputs come from clock_i logic
`timescale 1ns/10ps
`include "serial_frame_defs.svh"

module async_serial_frame_format #(
	parameter int DIV_W = 8,
	parameter int EXT_W = 8,
	parameter int DEPTH = `SF_FIFO_DEPTH
) (
	input  wire logic             clock_i,
	input  wire logic             sys_rst_i,
	input  wire logic             word_length_nine_i,
	input  wire logic [7:0]       tx_data_i,
	input  wire logic             tx_ninth_bit_i,
	input  wire logic             tx_valid_i,
	output logic                  tx_ready_o,
	input  wire logic             send_break_i,
	input  wire logic             send_idle_i,
	input  wire logic [DIV_W-1:0] tx_baud_divider_i,
	input  wire logic [EXT_W-1:0] tx_extended_prescaler_i,
	input  wire logic [DIV_W-1:0] rx_baud_divider_i,
	input  wire logic [EXT_W-1:0] rx_extended_prescaler_i,
	output logic                  txd_o,
	input  wire logic             rxd_i,
	output logic [7:0]            rx_data_o,
	output logic                  rx_ninth_bit_o,
	output logic                  rx_valid_o,
	output logic                  rx_break_o,
	output logic                  rx_idle_o,
	output logic                  rx_frame_error_o,
	output logic                  tx_busy_o,
	output logic                  rx_busy_o
);

	// ----------------------------------------------------------------
	// baud generators, index 0 transmit, index 1 receive
	// ----------------------------------------------------------------
	logic [DIV_W-1:0] div_lim [2];
	logic [EXT_W-1:0] ext_lim [2];
	logic [1:0]       tick;

	assign div_lim[0] = tx_baud_divider_i;
	assign ext_lim[0] = tx_extended_prescaler_i;
	assign div_lim[1] = rx_baud_divider_i;
	assign ext_lim[1] = rx_extended_prescaler_i;

	// tick rate = clock / ((div+1)*(ext+1)); one bit is 16 ticks
	for (genvar g = 0; g < 2; g++) begin : g_baud
		logic [DIV_W-1:0] div_q;
		logic [DIV_W-1:0] div_d;
		logic [EXT_W-1:0] ext_q;
		logic [EXT_W-1:0] ext_d;
		logic             tick_d;
		logic             tick_q;

		always_comb begin
			div_d  = DIV_W'(div_q + 1'b1);
			ext_d  = ext_q;
			tick_d = 1'b0;
			if (div_q >= div_lim[g]) begin
				div_d = '0;
				ext_d = EXT_W'(ext_q + 1'b1);
				if (ext_q >= ext_lim[g]) begin
					ext_d  = '0;
					tick_d = 1'b1;
				end
			end
		end

		always_ff @(posedge clock_i) begin
			if (sys_rst_i) begin
				div_q  <= '0;
				ext_q  <= '0;
				tick_q <= 1'b0;
			end else begin
				div_q  <= div_d;
				ext_q  <= ext_d;
				tick_q <= tick_d;
			end
		end

		assign tick[g] = tick_q;
	end

	// ----------------------------------------------------------------
	// transmit fifo
	// ----------------------------------------------------------------
	word_stream_if #(.WIDTH(`SF_WORD_W)) fill_w ();
	word_stream_if #(.WIDTH(`SF_WORD_W)) drain_w ();

	assign fill_w.valid = tx_valid_i;
	assign fill_w.data  = {tx_ninth_bit_i, tx_data_i};
	assign tx_ready_o   = fill_w.ready;

	frame_fifo #(
		.WIDTH (`SF_WORD_W),
		.DEPTH (DEPTH)
	) u_tx_fifo (
		.clock_i   (clock_i),
		.sys_rst_i (sys_rst_i),
		.fill_s    (fill_w),
		.drain_s   (drain_w)
	);

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	serial_frame_pkg::tx_state_e tx_st_q;
	serial_frame_pkg::tx_state_e tx_st_d;
	logic [`SF_OS_W-1:0]         tx_os_q;
	logic [`SF_OS_W-1:0]         tx_os_d;
	logic [`SF_BIT_W-1:0]        tx_bit_q;
	logic [`SF_BIT_W-1:0]        tx_bit_d;
	logic [`SF_WORD_W-1:0]       tx_sh_q;
	logic [`SF_WORD_W-1:0]       tx_sh_d;
	logic                        tx_nine_q;
	logic                        tx_nine_d;
	logic                        brk_pend_q;
	logic                        brk_pend_d;
	logic                        idl_pend_q;
	logic                        idl_pend_d;
	logic                        txd_q;
	logic                        txd_d;
	logic                        tx_bit_end;
	logic [`SF_BIT_W-1:0]        tx_frame_len;
	logic [`SF_BIT_W-1:0]        tx_data_last;

	assign tx_bit_end    = tick[0] & (tx_os_q == `SF_OS_LAST);
	assign tx_frame_len  = tx_nine_q ? `SF_FRAME_9 : `SF_FRAME_8;
	assign tx_data_last  = tx_nine_q ? `SF_DATA_LAST_9 : `SF_DATA_LAST_8;
	// requests for break and idle take priority over queued data
	assign drain_w.ready = (tx_st_q == serial_frame_pkg::TX_IDLE) & ~brk_pend_q & ~idl_pend_q;

	always_comb begin
		tx_st_d    = tx_st_q;
		tx_os_d    = tick[0] ? `SF_OS_W'(tx_os_q + 1'b1) : tx_os_q;
		tx_bit_d   = tx_bit_q;
		tx_sh_d    = tx_sh_q;
		tx_nine_d  = tx_nine_q;
		// a request landing as the previous one is taken is kept
		brk_pend_d = brk_pend_q | send_break_i;
		idl_pend_d = idl_pend_q | send_idle_i;
		case (tx_st_q)
			serial_frame_pkg::TX_IDLE: begin
				tx_os_d   = `SF_OS_ZERO;
				tx_bit_d  = `SF_BIT_ZERO;
				tx_nine_d = word_length_nine_i;
				if (brk_pend_q) begin
					brk_pend_d = send_break_i;
					tx_st_d    = serial_frame_pkg::TX_BREAK;
				end else if (idl_pend_q) begin
					idl_pend_d = send_idle_i;
					tx_st_d    = serial_frame_pkg::TX_IDLE_CH;
				end else if (drain_w.valid) begin
					tx_sh_d = drain_w.data;
					tx_st_d = serial_frame_pkg::TX_START;
				end
			end
			serial_frame_pkg::TX_START: begin
				if (tx_bit_end) begin
					tx_st_d = serial_frame_pkg::TX_DATA;
				end
			end
			serial_frame_pkg::TX_DATA: begin
				if (tx_bit_end) begin
					tx_sh_d  = tx_sh_q >> 1;
					tx_bit_d = `SF_BIT_W'(tx_bit_q + 1'b1);
					if (tx_bit_q == tx_data_last) begin
						tx_st_d = serial_frame_pkg::TX_STOP;
					end
				end
			end
			serial_frame_pkg::TX_STOP: begin
				if (tx_bit_end) begin
					tx_st_d = serial_frame_pkg::TX_IDLE;
				end
			end
			serial_frame_pkg::TX_BREAK: begin
				if (tx_bit_end) begin
					tx_bit_d = `SF_BIT_W'(tx_bit_q + 1'b1);
					if (tx_bit_q == `SF_BIT_W'(tx_frame_len - 1'b1)) begin
						tx_bit_d = `SF_BIT_ZERO;
						// back-to-back breaks merge, the mark follows the last one
						if (brk_pend_q) begin
							brk_pend_d = send_break_i;
						end else begin
							tx_st_d = serial_frame_pkg::TX_MARK;
						end
					end
				end
			end
			serial_frame_pkg::TX_MARK: begin
				if (tx_bit_end) begin
					tx_st_d = serial_frame_pkg::TX_IDLE;
				end
			end
			serial_frame_pkg::TX_IDLE_CH: begin
				if (tx_bit_end) begin
					tx_bit_d = `SF_BIT_W'(tx_bit_q + 1'b1);
					if (tx_bit_q == `SF_BIT_W'(tx_frame_len - 1'b1)) begin
						tx_st_d = serial_frame_pkg::TX_IDLE;
					end
				end
			end
			default: begin
				tx_st_d = serial_frame_pkg::TX_IDLE;
			end
		endcase
		case (tx_st_d)
			serial_frame_pkg::TX_START: txd_d = 1'b0;
			serial_frame_pkg::TX_BREAK: txd_d = 1'b0;
			serial_frame_pkg::TX_DATA:  txd_d = tx_sh_d[0];
			serial_frame_pkg::TX_STOP:  txd_d = 1'b1;
			default:                    txd_d = 1'b1;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			tx_st_q    <= serial_frame_pkg::TX_IDLE;
			tx_os_q    <= `SF_OS_ZERO;
			tx_bit_q   <= `SF_BIT_ZERO;
			tx_sh_q    <= `SF_WORD_ZERO;
			tx_nine_q  <= 1'b0;
			brk_pend_q <= 1'b0;
			idl_pend_q <= 1'b0;
			txd_q      <= `SF_LINE_IDLE;
		end else begin
			tx_st_q    <= tx_st_d;
			tx_os_q    <= tx_os_d;
			tx_bit_q   <= tx_bit_d;
			tx_sh_q    <= tx_sh_d;
			tx_nine_q  <= tx_nine_d;
			brk_pend_q <= brk_pend_d;
			idl_pend_q <= idl_pend_d;
			txd_q      <= txd_d;
		end
	end

	assign txd_o     = txd_q;
	assign tx_busy_o = (tx_st_q != serial_frame_pkg::TX_IDLE);

	// ----------------------------------------------------------------
	// receive line synchroniser
	// ----------------------------------------------------------------
	logic rxd_meta_q;
	logic rxd_q;

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rxd_meta_q <= `SF_LINE_IDLE;
			rxd_q      <= `SF_LINE_IDLE;
		end else begin
			rxd_meta_q <= rxd_i;
			rxd_q      <= rxd_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// receiver, samples each bit at its middle tick
	// ----------------------------------------------------------------
	serial_frame_pkg::rx_state_e rx_st_q;
	serial_frame_pkg::rx_state_e rx_st_d;
	logic [`SF_OS_W-1:0]         rx_os_q;
	logic [`SF_OS_W-1:0]         rx_os_d;
	logic [`SF_BIT_W-1:0]        rx_bit_q;
	logic [`SF_BIT_W-1:0]        rx_bit_d;
	logic [`SF_WORD_W-1:0]       rx_sh_q;
	logic [`SF_WORD_W-1:0]       rx_sh_d;
	logic                        rx_nine_q;
	logic                        rx_nine_d;
	logic                        idle_arm_q;
	logic                        idle_arm_d;
	logic [7:0]                  rx_data_q;
	logic [7:0]                  rx_data_d;
	logic                        rx_r9_q;
	logic                        rx_r9_d;
	logic                        rx_vld_q;
	logic                        rx_vld_d;
	logic                        rx_brk_q;
	logic                        rx_brk_d;
	logic                        rx_idl_q;
	logic                        rx_idl_d;
	logic                        rx_fe_q;
	logic                        rx_fe_d;
	logic                        rx_mid;
	logic                        rx_end;
	logic [`SF_WORD_W-1:0]       rx_word;

	assign rx_mid  = tick[1] & (rx_os_q == `SF_OS_MID);
	assign rx_end  = tick[1] & (rx_os_q == `SF_OS_LAST);
	// in 8-bit frames the first bit lands one place higher
	assign rx_word = rx_nine_q ? rx_sh_q : {1'b0, rx_sh_q[8:1]};

	always_comb begin
		rx_st_d    = rx_st_q;
		rx_os_d    = tick[1] ? `SF_OS_W'(rx_os_q + 1'b1) : rx_os_q;
		rx_bit_d   = rx_bit_q;
		rx_sh_d    = rx_sh_q;
		rx_nine_d  = rx_nine_q;
		idle_arm_d = idle_arm_q;
		rx_data_d  = rx_data_q;
		rx_r9_d    = rx_r9_q;
		rx_vld_d   = 1'b0;
		rx_brk_d   = 1'b0;
		rx_idl_d   = 1'b0;
		rx_fe_d    = 1'b0;
		case (rx_st_q)
			serial_frame_pkg::RX_IDLE: begin
				rx_nine_d = word_length_nine_i;
				if (!rxd_q) begin
					rx_os_d  = `SF_OS_ZERO;
					rx_bit_d = `SF_BIT_ZERO;
					rx_st_d  = serial_frame_pkg::RX_START;
				end else if (rx_end) begin
					rx_bit_d = `SF_BIT_W'(rx_bit_q + 1'b1);
					// a whole frame time of ones after traffic
					if (rx_bit_q == `SF_BIT_W'((rx_nine_q ? `SF_FRAME_9 : `SF_FRAME_8)
					                          - 1'b1)) begin
						rx_idl_d   = idle_arm_q;
						idle_arm_d = 1'b0;
						rx_bit_d   = `SF_BIT_ZERO;
					end
				end
			end
			serial_frame_pkg::RX_START: begin
				if (rx_mid && rxd_q) begin
					rx_os_d  = `SF_OS_ZERO;
					rx_bit_d = `SF_BIT_ZERO;
					rx_st_d  = serial_frame_pkg::RX_IDLE;
				end else if (rx_end) begin
					rx_st_d = serial_frame_pkg::RX_DATA;
				end
			end
			serial_frame_pkg::RX_DATA: begin
				if (rx_mid) begin
					rx_sh_d = {rxd_q, rx_sh_q[8:1]};
				end
				if (rx_end) begin
					rx_bit_d = `SF_BIT_W'(rx_bit_q + 1'b1);
					if (rx_bit_q == (rx_nine_q ? `SF_DATA_LAST_9 : `SF_DATA_LAST_8)) begin
						rx_st_d = serial_frame_pkg::RX_STOP;
					end
				end
			end
			serial_frame_pkg::RX_STOP: begin
				// leave at mid-stop so the next start edge is not missed
				if (rx_mid) begin
					idle_arm_d = 1'b1;
					rx_os_d    = `SF_OS_ZERO;
					rx_bit_d   = `SF_BIT_ZERO;
					rx_st_d    = serial_frame_pkg::RX_IDLE;
					if (rxd_q) begin
						rx_data_d = rx_word[7:0];
						rx_r9_d   = rx_nine_q & rx_word[8];
						rx_vld_d  = 1'b1;
					end else if (rx_word == `SF_WORD_ZERO) begin
						rx_brk_d = 1'b1;
					end else begin
						rx_fe_d = 1'b1;
					end
				end
			end
			default: begin
				rx_st_d = serial_frame_pkg::RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rx_st_q    <= serial_frame_pkg::RX_IDLE;
			rx_os_q    <= `SF_OS_ZERO;
			rx_bit_q   <= `SF_BIT_ZERO;
			rx_sh_q    <= `SF_WORD_ZERO;
			rx_nine_q  <= 1'b0;
			idle_arm_q <= 1'b0;
			rx_data_q  <= 8'h00;
			rx_r9_q    <= 1'b0;
			rx_vld_q   <= 1'b0;
			rx_brk_q   <= 1'b0;
			rx_idl_q   <= 1'b0;
			rx_fe_q    <= 1'b0;
		end else begin
			rx_st_q    <= rx_st_d;
			rx_os_q    <= rx_os_d;
			rx_bit_q   <= rx_bit_d;
			rx_sh_q    <= rx_sh_d;
			rx_nine_q  <= rx_nine_d;
			idle_arm_q <= idle_arm_d;
			rx_data_q  <= rx_data_d;
			rx_r9_q    <= rx_r9_d;
			rx_vld_q   <= rx_vld_d;
			rx_brk_q   <= rx_brk_d;
			rx_idl_q   <= rx_idl_d;
			rx_fe_q    <= rx_fe_d;
		end
	end

	assign rx_data_o        = rx_data_q;
	assign rx_ninth_bit_o   = rx_r9_q;
	assign rx_valid_o       = rx_vld_q;
	assign rx_break_o       = rx_brk_q;
	assign rx_idle_o        = rx_idl_q;
	assign rx_frame_error_o = rx_fe_q;
	assign rx_busy_o        = (rx_st_q != serial_frame_pkg::RX_IDLE);

endmodule : async_serial_frame_format

// ---- serial_frame_sva.sv ----
// checker for the serial frame engine, bound onto its top ports
// assumes one clock domain and at least 16 clocks per bit on each side
`timescale 1ns/10ps
module serial_frame_sva (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic txd_o,
	input wire logic rxd_i,
	input wire logic tx_busy_o,
	input wire logic rx_busy_o,
	input wire logic tx_ready_o,
	input wire logic rx_valid_o,
	input wire logic rx_break_o,
	input wire logic rx_frame_error_o,
	input wire logic rx_idle_o
);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	reset_idle_a: assert property ($fell(sys_rst_i) |-> txd_o && tx_ready_o && !tx_busy_o && !rx_busy_o)
		else $error("line or flags not idle after reset");
	idle_line_a: assert property (!tx_busy_o |-> txd_o)
		else $error("transmit line low while idle");
	low_run_a: assert property ($fell(txd_o) |-> !txd_o [*8])
		else $error("low bit on transmit line too short");
	high_run_a: assert property ($rose(txd_o) |-> txd_o [*8])
		else $error("high bit on transmit line too short");
	valid_pulse_a: assert property (rx_valid_o |=> !rx_valid_o)
		else $error("receive strobe longer than one cycle");
	valid_stop_a: assert property (rx_valid_o |-> $past(rxd_i, 4) && $past(rx_busy_o, 3))
		else $error("word accepted without high stop bit");
	break_stop_a: assert property (rx_break_o |-> !$past(rxd_i, 4) && !rx_valid_o)
		else $error("break flagged on high line");
	ferr_stop_a: assert property (rx_frame_error_o |-> !$past(rxd_i, 4) && !rx_valid_o)
		else $error("framing error on high stop bit");
	idle_excl_a: assert property (rx_idle_o |-> !rx_valid_o && !rx_busy_o)
		else $error("idle flagged inside a frame");

	// ----------------------------------------------------------------
	// covers
	// ----------------------------------------------------------------
	cover property (rx_valid_o);
	cover property (rx_break_o);
	cover property (rx_frame_error_o);
	cover property (rx_idle_o);
endmodule : serial_frame_sva

// ---- serial_node.sv ----
// remote serial node: decodes the transmit line, drives the receive line
// assumes bit times given in clocks; line rests high between frames
`timescale 1ns/10ps
module serial_node #(
	parameter int BIT_IN  = 32,
	parameter int BIT_OUT = 16
) (
	input  wire logic clock_i,
	input  wire logic line_i,
	input  wire logic nine_i,
	output logic      line_o
);
	logic [9:0] got_q[$];

	initial line_o = 1'b1;

	// ----------------------------------------------------------------
	// decoder: {stop, ninth, byte}, sampled mid-bit
	// ----------------------------------------------------------------
	always begin : decode
		logic [9:0] w;
		int         n;
		@(negedge line_i);
		n = nine_i ? 9 : 8;
		w = 10'h000;
		repeat (BIT_IN / 2) @(posedge clock_i);
		for (int i = 0; i < n; i++) begin
			repeat (BIT_IN) @(posedge clock_i);
			w[i] = line_i;
		end
		repeat (BIT_IN) @(posedge clock_i);
		w[9] = line_i;
		got_q.push_back(w);
		// break frame: no new start until the line has risen
		if (!w[9]) wait (line_i === 1'b1);
	end

	task automatic send(input logic [8:0] w, input int n, input logic stop);
		line_o <= 1'b0;
		repeat (BIT_OUT) @(posedge clock_i);
		for (int i = 0; i < n; i++) begin
			line_o <= w[i];
			repeat (BIT_OUT) @(posedge clock_i);
		end
		line_o <= stop;
		repeat (BIT_OUT) @(posedge clock_i);
		// one idle clock so back-to-back calls never drive the line twice in a step
		line_o <= 1'b1;
		@(posedge clock_i);
	endtask : send
endmodule : serial_node

// ---- tb.sv ----
// self-checking bench for the serial frame engine and its fifo
// assumes tx bit = 32 clocks (prescaler 1), rx bit = 16 clocks
`timescale 1ns/10ps
module tb;
	localparam int TXB = 32;
	localparam int RXB = 16;
	localparam int LIMIT = 60000;

	logic       clock_i = 1'b0, sys_rst_i = 1'b1, word_length_nine_i = 1'b0;
	logic       tx_ninth_bit_i = 1'b0, tx_valid_i = 1'b0, send_break_i = 1'b0;
	logic       send_idle_i = 1'b0, saw_full = 1'b0;
	logic [7:0] tx_data_i = 8'h00, rx_data_o;
	logic       tx_ready_o, txd_o, rxd_i, rx_ninth_bit_o, rx_valid_o, rx_break_o;
	logic       rx_idle_o, rx_frame_error_o, tx_busy_o, rx_busy_o;
	int         err_count = 0, samples_checked = 0, cycles = 0, nb = 0, nf = 0, ni = 0;
	logic [9:0] exp_q[$], rx_q[$];

	async_serial_frame_format i_async_serial_frame_format (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .word_length_nine_i(word_length_nine_i),
		.tx_data_i(tx_data_i), .tx_ninth_bit_i(tx_ninth_bit_i), .tx_valid_i(tx_valid_i),
		.tx_ready_o(tx_ready_o), .send_break_i(send_break_i), .send_idle_i(send_idle_i),
		.tx_baud_divider_i(8'h00), .tx_extended_prescaler_i(8'h01),
		.rx_baud_divider_i(8'h00), .rx_extended_prescaler_i(8'h00),
		.txd_o(txd_o), .rxd_i(rxd_i), .rx_data_o(rx_data_o), .rx_ninth_bit_o(rx_ninth_bit_o),
		.rx_valid_o(rx_valid_o), .rx_break_o(rx_break_o), .rx_idle_o(rx_idle_o),
		.rx_frame_error_o(rx_frame_error_o), .tx_busy_o(tx_busy_o), .rx_busy_o(rx_busy_o));

	serial_node #(.BIT_IN(TXB), .BIT_OUT(RXB)) i_serial_node (
		.clock_i(clock_i), .line_i(txd_o), .nine_i(word_length_nine_i), .line_o(rxd_i));

	always #5 clock_i = ~clock_i;

	// ----------------------------------------------------------------
	// monitor and watchdog
	// ----------------------------------------------------------------
	always @(posedge clock_i) begin
		if (rx_valid_o === 1'b1) rx_q.push_back({1'b1, rx_ninth_bit_o, rx_data_o});
		nb += (rx_break_o === 1'b1);
		nf += (rx_frame_error_o === 1'b1);
		ni += (rx_idle_o === 1'b1);
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			stop_test();
		end
	end

	task automatic check(input logic [9:0] seen, input logic [9:0] want);
		samples_checked++;
		if (seen !== want) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	function automatic logic [9:0] frame_of(input logic [8:0] w, input logic nine);
		return {1'b1, nine & w[8], w[7:0]};
	endfunction : frame_of

	task automatic push(input logic [8:0] w);
		int k;
		k = 0;
		tx_data_i      <= w[7:0];
		tx_ninth_bit_i <= w[8];
		tx_valid_i     <= 1'b1;
		@(posedge clock_i);
		while (tx_ready_o !== 1'b1 && k < 9000) begin
			saw_full = 1'b1;
			@(posedge clock_i);
			k++;
		end
	endtask : push

	// compare what a queue collected against expectations
	task automatic drain(ref logic [9:0] got[$], input int n);
		int k;
		k = 0;
		while (got.size() < n && k < 20000) begin
			@(posedge clock_i);
			k++;
		end
		check(10'(got.size()), 10'(n));
		while (got.size() > 0 && exp_q.size() > 0) check(got.pop_front(), exp_q.pop_front());
		got.delete();
		exp_q.delete();
	endtask : drain

	// break or idle character; returns low and high cycles while busy
	task automatic tx_special(input logic brk, output int lo, output int hi);
		int k;
		k  = 0;
		lo = 0;
		hi = 0;
		if (brk) send_break_i <= 1'b1;
		else send_idle_i <= 1'b1;
		@(posedge clock_i);
		send_break_i <= 1'b0;
		send_idle_i  <= 1'b0;
		while (tx_busy_o !== 1'b1 && k < 100) begin
			@(posedge clock_i);
			k++;
		end
		while (tx_busy_o === 1'b1 && k < 3000) begin
			if (txd_o === 1'b0) lo++;
			else hi++;
			@(posedge clock_i);
			k++;
		end
	endtask : tx_special

	initial begin : main
		int         lo, hi, fl, b0, f0, i0;
		logic [8:0] w;
		void'($urandom(25));
		repeat (3) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
		check({tx_ready_o, txd_o, tx_busy_o, rx_busy_o}, 10'h00C);
		for (int m = 0; m < 2; m++) begin
			// word length changes only with both directions idle
			word_length_nine_i <= m[0];
			@(posedge clock_i);
			saw_full = 1'b0;
			for (int i = 0; i < (m == 0 ? 20 : 5); i++) begin
				w = (i == 0) ? 9'h1FF : 9'($urandom);
				push(w);
				exp_q.push_back(frame_of(w, m[0]));
			end
			tx_valid_i <= 1'b0;
			if (m == 0) check({9'h000, saw_full}, 10'h001);
			drain(i_serial_node.got_q, m == 0 ? 20 : 5);
			repeat (TXB) @(posedge clock_i);
			check({tx_busy_o, tx_ready_o}, 10'h001);
			$display("transmit words, %0d data bits: done", 8 + m);
			fl = (10 + m) * TXB;
			tx_special(1'b1, lo, hi);
			check(10'(lo >= fl - 3 && lo <= fl + 1), 10'h001);
			check(10'(hi >= TXB - 3 && hi <= TXB + 3), 10'h001);
			exp_q.push_back(10'h000);
			drain(i_serial_node.got_q, 1);
			tx_special(1'b0, lo, hi);
			check(10'(lo), 10'h000);
			check(10'(hi >= fl - 3 && hi <= fl + 3), 10'h001);
			$display("break and idle characters, %0d data bits: done", 8 + m);
			for (int i = 0; i < 6; i++) begin
				w = (i == 0) ? 9'h100 : 9'($urandom);
				exp_q.push_back(frame_of(w, m[0]));
				i_serial_node.send(w, 8 + m, 1'b1);
			end
			i0 = ni;
			repeat (12 * (10 + m) * RXB / 10 + 8) @(posedge clock_i);
			drain(rx_q, 6);
			check(10'(ni - i0), 10'h001);
			b0 = nb;
			f0 = nf;
			i_serial_node.send(9'h000, 8 + m, 1'b0);
			repeat (RXB) @(posedge clock_i);
			i_serial_node.send(9'h0A5, 8 + m, 1'b0);
			repeat (12 * RXB) @(posedge clock_i);
			check({10'(nb - b0)}, 10'h001);
			check({10'(nf - f0)}, 10'h001);
			check(10'(rx_q.size()), 10'h000);
			$display("receive frames, %0d data bits: done", 8 + m);
		end
		stop_test();
	end
endmodule : tb

bind async_serial_frame_format serial_frame_sva i_serial_frame_sva (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .txd_o(txd_o), .rxd_i(rxd_i),
	.tx_busy_o(tx_busy_o), .rx_busy_o(rx_busy_o), .tx_ready_o(tx_ready_o),
	.rx_valid_o(rx_valid_o), .rx_break_o(rx_break_o), .rx_frame_error_o(rx_frame_error_o),
	.rx_idle_o(rx_idle_o));
